// File: rtl/freq_counter_pkg.sv
// Constants for the gated frequency counter.
//
// Contract
// - Counter counts event edges only while the window gate is high.
// - Window source select 00 uses the external gate pin as gate.
// - Interrupt on gate falling edge, or both edges, per edge select.
// - Without a clear, counting resumes from the previous value.
// - Current gate state is readable as a read-only status flag.
// - Wrap from maximum to zero sets the overflow flag.
// - Overflow flag holds until software clears the counter.
// - Route bit only gates neighbour output to the port pin.
// - Internal gate alternates high period Ta and low period Tb.
// - Each phase lasts 16 minus setting prescaled ticks.
// - First internal high period may start one prescale tick late.
// - Low setting written during low period applies from next low period.
// - Gate mode 1 adds one on every gate falling edge.
// - Gate mode 0 counts falls of input AND gate.
// - Window flag is 1 while counting in high, else 0.
package freq_counter_pkg;
   // ==========================================================
   // Register offsets (byte addresses).
   localparam logic [4:0] CTRL_ONE_ADDR   = 5'h00;
   localparam logic [4:0] CTRL_TWO_ADDR   = 5'h04;
   localparam logic [4:0] RESULT_ADDR     = 5'h08;
   localparam logic [4:0] PERIOD_ADDR     = 5'h0c;
   localparam logic [4:0] STATUS_ADDR     = 5'h10;
   // ==========================================================
   // Field positions.
   localparam int RUN_LSB   = 0;
   localparam int SRC_LSB   = 2;
   localparam int CLEAR_BIT = 4;
   localparam int WSRC_LSB  = 0;
   localparam int EDGE_BIT  = 2;
   localparam int SEG_BIT   = 3;
   localparam int PSC_LSB   = 4;
   localparam int DIV_BIT   = 6;
   localparam int ROUTE_BIT = 7;
   localparam int TA_LSB    = 0;
   localparam int TB_LSB    = 4;
   localparam int WFLAG_BIT = 7;
   localparam int OVF_BIT   = 6;
   // ==========================================================
   // Field codes and reset values.
   localparam logic [1:0] RUN_STOP   = 2'h0;
   localparam logic [1:0] RUN_START  = 2'h2;
   localparam logic [1:0] SRC_EXT    = 2'h3;
   localparam logic [1:0] WSRC_PIN   = 2'h0;
   localparam logic [1:0] WSRC_NBR   = 2'h1;
   localparam logic [1:0] WSRC_INT   = 2'h2;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] PERIOD_RST = 8'h00;
   localparam logic [4:0] PHASE_BASE = 5'h10;
   // Prescale tick widths: fc path 2^12, fs path 2^4.
   localparam int FC_SHIFT   = 12;
   localparam int FS_SHIFT   = 4;
   localparam int FC_DIV_W   = 14;
   localparam int FS_DIV_W   = 6;
endpackage

// File: rtl/gated_frequency_counter.sv
// Gated frequency counter with internal window gate generator.
`timescale 1ns/100ps
`default_nettype none
module gated_frequency_counter #(
   parameter int COUNT_W = 18
) (
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   input  wire logic [4:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   input  wire logic        event_input_pin_in,
   input  wire logic        external_gate_input_in,
   input  wire logic        neighbor_timer_output_in,
   input  wire logic        low_freq_clock_in,
   output logic             counter_interrupt_out,
   output logic             shared_port_pin_out
);
   // ==========================================================
   // Elaboration check.
   if (COUNT_W < 2 || COUNT_W > 32) begin : g_chk
      $error("COUNT_W must lie in 2..32");
   end

   typedef enum logic [1:0] {GEN_IDLE, GEN_HIGH, GEN_LOW} gen_t;

   // True when the low bits of a divider are all ones.
   function automatic logic tick_of(input logic [13:0] val,
                                    input int          bits);
      logic [13:0] mask;
      mask = 14'((15'h1 << bits) - 15'h1);
      tick_of = ((val & mask) == mask);
   endfunction

   // ==========================================================
   // Registers.
   logic [7:0]         ctrl_one;
   logic [7:0]         ctrl_two;
   logic [7:0]         period;
   logic [COUNT_W-1:0] count;
   logic               overflow_flag;
   logic               clear_pulse;

   logic [1:0] run_control_field;
   logic [1:0] source_clock_select;
   logic [1:0] window_source_select;
   logic       window_irq_edge_select;
   logic       gate_mode_select;
   logic [1:0] window_prescale_select;
   logic       divider_stage_select;
   logic       neighbor_output_route_bit;
   logic       running;

   assign run_control_field =
      ctrl_one[freq_counter_pkg::RUN_LSB +: 2];
   assign source_clock_select =
      ctrl_one[freq_counter_pkg::SRC_LSB +: 2];
   assign window_source_select =
      ctrl_two[freq_counter_pkg::WSRC_LSB +: 2];
   assign window_irq_edge_select = ctrl_two[freq_counter_pkg::EDGE_BIT];
   assign gate_mode_select = ctrl_two[freq_counter_pkg::SEG_BIT];
   assign window_prescale_select =
      ctrl_two[freq_counter_pkg::PSC_LSB +: 2];
   assign divider_stage_select = ctrl_two[freq_counter_pkg::DIV_BIT];
   assign neighbor_output_route_bit =
      ctrl_two[freq_counter_pkg::ROUTE_BIT];
   // Counting needs start plus the external event source selected.
   assign running = (run_control_field == freq_counter_pkg::RUN_START) &&
      (source_clock_select == freq_counter_pkg::SRC_EXT);

   // Control writes; the clear bit is a one-cycle pulse, never stored.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_one    <= freq_counter_pkg::CTRL_RESET;
         ctrl_two    <= freq_counter_pkg::CTRL_RESET;
         period      <= freq_counter_pkg::PERIOD_RST;
         clear_pulse <= 1'b0;
      end else begin
         clear_pulse <= 1'b0;
         if (wr_in) begin
            unique case (addr_in)
               freq_counter_pkg::CTRL_ONE_ADDR: begin
                  ctrl_one <= wdata_in[7:0] &
                     ~(8'h01 << freq_counter_pkg::CLEAR_BIT);
                  clear_pulse <= wdata_in[freq_counter_pkg::CLEAR_BIT];
               end
               freq_counter_pkg::CTRL_TWO_ADDR: ctrl_two <= wdata_in[7:0];
               freq_counter_pkg::PERIOD_ADDR:   period   <= wdata_in[7:0];
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // Input synchronisers.
   logic [1:0] ev_sync;
   logic [1:0] gp_sync;
   logic [1:0] fs_sync;
   logic       fs_prev;

   // Two flops on the event, gate and fs pins so each edge is seen exactly once; the neighbour output is used unsynchronised.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ev_sync <= 2'h0;
         gp_sync <= 2'h0;
         fs_sync <= 2'h0;
         fs_prev <= 1'b0;
      end else begin
         ev_sync <= {ev_sync[0], event_input_pin_in};
         gp_sync <= {gp_sync[0], external_gate_input_in};
         fs_sync <= {fs_sync[0], low_freq_clock_in};
         fs_prev <= fs_sync[1];
      end
   end

   // ==========================================================
   // Prescale dividers.
   logic [freq_counter_pkg::FC_DIV_W-1:0] fc_div;
   logic [freq_counter_pkg::FS_DIV_W-1:0] fs_div;
   logic fs_edge;
   logic win_tick;
   assign fs_edge = fs_sync[1] && !fs_prev;

   // Both dividers run free; the gate locks to them, so a start may
   // lose up to one tick before the first high period.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fc_div <= '0;
         fs_div <= '0;
      end else begin
         fc_div <= fc_div + 1'b1;
         if (fs_edge) begin
            fs_div <= fs_div + 1'b1;
         end
      end
   end

   // Selects the tick: fc/2^12..2^14 or fs/2^4..2^6.
   always_comb begin
      if (divider_stage_select) begin
         win_tick = fs_edge && tick_of(14'(fs_div),
            freq_counter_pkg::FS_SHIFT +
            int'(window_prescale_select));
      end else begin
         win_tick = tick_of(fc_div, freq_counter_pkg::FC_SHIFT +
            int'(window_prescale_select));
      end
   end

   // ==========================================================
   // Internal window gate generator.
   gen_t       gen_state;
   logic [4:0] phase_left;
   logic [3:0] ta_set;
   logic [3:0] tb_set;
   assign ta_set = period[freq_counter_pkg::TA_LSB +: 4];
   assign tb_set = period[freq_counter_pkg::TB_LSB +: 4];

   // Each phase length is sampled at its start, so a new low setting
   // written during a low phase applies from the next low phase.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         gen_state  <= GEN_IDLE;
         phase_left <= 5'h00;
      end else if (!running ||
         window_source_select != freq_counter_pkg::WSRC_INT) begin
         gen_state  <= GEN_IDLE;
         phase_left <= 5'h00;
      end else if (win_tick) begin
         unique case (gen_state)
            GEN_IDLE: begin
               gen_state  <= GEN_HIGH;
               phase_left <= freq_counter_pkg::PHASE_BASE - 5'(ta_set);
            end
            GEN_HIGH: begin
               if (phase_left == 5'h01) begin
                  gen_state  <= GEN_LOW;
                  phase_left <= freq_counter_pkg::PHASE_BASE -
                     5'(tb_set);
               end else begin
                  phase_left <= phase_left - 5'h01;
               end
            end
            GEN_LOW: begin
               if (phase_left == 5'h01) begin
                  gen_state  <= GEN_HIGH;
                  phase_left <= freq_counter_pkg::PHASE_BASE -
                     5'(ta_set);
               end else begin
                  phase_left <= phase_left - 5'h01;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Gate selection and edge detection.
   logic gate_src;
   logic gate;
   logic gate_prev;
   logic and_prev;
   logic ev_prev;
   logic gate_fall;
   logic gate_rise;
   logic cnt_step;

   always_comb begin
      unique case (window_source_select)
         freq_counter_pkg::WSRC_PIN: gate_src = gp_sync[1];
         freq_counter_pkg::WSRC_NBR: gate_src = neighbor_timer_output_in;
         freq_counter_pkg::WSRC_INT: gate_src = (gen_state == GEN_HIGH);
         default:                    gate_src = 1'b0;
      endcase
   end
   assign gate      = gate_src && running;
   assign gate_fall = gate_prev && !gate;
   assign gate_rise = !gate_prev && gate;

   // Mode 0 counts falls of input AND gate; mode 1 counts input falls
   // inside the window and always adds one at the gate fall.
   always_comb begin
      if (gate_mode_select) begin
         cnt_step = gate_fall ||
            (gate && ev_prev && !ev_sync[1]);
      end else begin
         cnt_step = and_prev && !(ev_sync[1] && gate);
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         gate_prev <= 1'b0;
         and_prev  <= 1'b0;
         ev_prev   <= 1'b0;
      end else begin
         gate_prev <= gate;
         and_prev  <= ev_sync[1] && gate;
         ev_prev   <= ev_sync[1];
      end
   end

   // ==========================================================
   // Counter and overflow flag.
   logic wrap;
   assign wrap = cnt_step && (&count);

   // A clear zeroes the count; a wrap in the same cycle still sets
   // the overflow flag so the event is not lost.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         count <= '0;
      end else if (clear_pulse) begin
         count <= '0;
      end else if (cnt_step) begin
         count <= count + 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         overflow_flag <= 1'b0;
      end else if (wrap) begin
         overflow_flag <= 1'b1;
      end else if (clear_pulse) begin
         overflow_flag <= 1'b0;
      end
   end

   // ==========================================================
   // Outputs.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         counter_interrupt_out <= 1'b0;
         shared_port_pin_out   <= 1'b0;
      end else begin
         counter_interrupt_out <= gate_fall ||
            (window_irq_edge_select && gate_rise);
         // Route bit only masks the pin; the neighbour keeps running.
         shared_port_pin_out <= !neighbor_output_route_bit &&
            neighbor_timer_output_in;
      end
   end

   // Read data stand in the cycle after the strobe only.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_out <= 32'h0000_0000;
      end else begin
         rdata_out <= 32'h0000_0000;
         if (rd_in) begin
            unique case (addr_in)
               freq_counter_pkg::CTRL_ONE_ADDR:
                  rdata_out <= {24'h000000, ctrl_one};
               freq_counter_pkg::CTRL_TWO_ADDR:
                  rdata_out <= {24'h000000, ctrl_two};
               freq_counter_pkg::RESULT_ADDR:
                  rdata_out <= 32'(count);
               freq_counter_pkg::PERIOD_ADDR:
                  rdata_out <= {24'h000000, period};
               freq_counter_pkg::STATUS_ADDR: begin
                  rdata_out[freq_counter_pkg::WFLAG_BIT] <= gate;
                  rdata_out[freq_counter_pkg::OVF_BIT] <= overflow_flag;
               end
               default: ;
            endcase
         end
      end
   end
endmodule // gated_frequency_counter
`default_nettype wire

// File: tb/event_source_model.sv
// Behavioural pulse source that drives the measured event input.
`timescale 1ns/100ps
`default_nettype none
module event_source_model (
   input  wire logic clk_in,
   output var logic  event_out
);
   initial event_out = 1'b0;
   // Each level lasts four clocks, so the synchroniser never misses an edge.
   task automatic pulses(input int n);
      repeat (n) begin
         repeat (4) @(posedge clk_in) event_out <= 1'b1;
         repeat (4) @(posedge clk_in) event_out <= 1'b0;
      end
   endtask
   // A steady level stands for a source that has stopped toggling.
   task automatic hold(input logic v);
      @(posedge clk_in) event_out <= v;
   endtask
endmodule // event_source_model
`default_nettype wire

// File: tb/gated_frequency_counter_bench.sv
// Self-checking bench for the gated frequency counter.
`timescale 1ns/100ps
`default_nettype none
module gated_frequency_counter_bench;
   localparam int CW = 4;
   logic        clk_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic [4:0]  addr_in = 5'h00;
   logic [31:0] wdata_in = 32'h0;
   logic        wr_in = 1'b0;
   logic        rd_in = 1'b0;
   logic        gate = 1'b0;
   logic        nbr = 1'b0;
   logic        fs = 1'b0;
   logic        rd_d = 1'b0;
   logic        ev;
   logic        irq;
   logic [31:0] rdata_out;
   logic [31:0] exp_q[$], msk_q[$], irq_t[$];
   int          err_count = 0, num_checks = 0, cyc = 0, n, m, t, w, s;
   // =====================================================
   // Clocks: fs rises every eight system clocks, so window ticks are exact.
   always #25 clk_in = ~clk_in;
   always begin
      repeat (4) @(posedge clk_in);
      fs <= ~fs;
   end
   gated_frequency_counter #(.COUNT_W(CW)) i_gated_frequency_counter (
      .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .event_input_pin_in(ev), .external_gate_input_in(gate),
      .neighbor_timer_output_in(nbr), .low_freq_clock_in(fs),
      .counter_interrupt_out(irq), .shared_port_pin_out());
   event_source_model i_event_source_model (.clk_in(clk_in), .event_out(ev));
   // =====================================================
   // Bus tasks and checks.
   task automatic end_sim;
      $display("Checks %0d, errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= {24'h0, d};
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] k);
      exp_q.push_back(e);
      msk_q.push_back(k);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
   endtask
   task automatic wait_irq(input int k);
      w = 0;
      while (irq_t.size() < k) begin
         @(posedge clk_in);
         w++;
         if (w > 20000) begin
            err_count++;
            $display("Error at %0t: interrupt missing", $time);
            end_sim();
         end
      end
   endtask
   // Pin-gated window with a flag read while the gate is high.
   task automatic window(input int p);
      @(posedge clk_in) gate <= 1'b1;
      repeat (6) @(posedge clk_in);
      rd(freq_counter_pkg::STATUS_ADDR, 32'h80, 32'h80);
      i_event_source_model.pulses(p);
      repeat (6) @(posedge clk_in);
      gate <= 1'b0;
      repeat (8) @(posedge clk_in);
   endtask
   // =====================================================
   // Watcher: read results leave by the queue, interrupts are time-stamped.
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      rd_d <= rd_in;
      nbr <= 1'($urandom);
   end
   always @(negedge clk_in) begin
      if (irq === 1'b1) irq_t.push_back(cyc);
      if (rd_d) chk(rdata_out & msk_q.pop_front(), exp_q.pop_front());
   end
   // =====================================================
   // Main sequence.
   initial begin
      void'($urandom(32'h5d0373b7));
      repeat (3) @(posedge clk_in);
      resetn_in <= 1'b1;
      repeat (16) @(posedge clk_in);
      for (int a = 0; a < 6; a++) rd(5'(a * 4), 32'h0, 32'hffffffff);
      n = $urandom | 32'h80;
      wr(freq_counter_pkg::CTRL_TWO_ADDR, n[7:0]);
      wr(freq_counter_pkg::PERIOD_ADDR, n[15:8]);
      wr(freq_counter_pkg::RESULT_ADDR, 8'hff);
      rd(freq_counter_pkg::CTRL_TWO_ADDR, {24'h0, n[7:0]}, 32'hffffffff);
      rd(freq_counter_pkg::PERIOD_ADDR, {24'h0, n[15:8]}, 32'hffffffff);
      rd(freq_counter_pkg::RESULT_ADDR, 32'h0, 32'hffffffff);
      // Pin gate, falling-edge interrupt, then both edges without a clear.
      wr(freq_counter_pkg::CTRL_TWO_ADDR, 8'h00);
      wr(freq_counter_pkg::CTRL_ONE_ADDR, 8'h1e);
      irq_t.delete();
      n = 3 + $urandom_range(3);
      window(n);
      rd(freq_counter_pkg::RESULT_ADDR, n, 32'hffffffff);
      chk(32'(irq_t.size()), 32'h1);
      wr(freq_counter_pkg::CTRL_ONE_ADDR, 8'h0c);
      wr(freq_counter_pkg::CTRL_TWO_ADDR, 8'h04);
      wr(freq_counter_pkg::CTRL_ONE_ADDR, 8'h0e);
      m = 1 + $urandom_range(3);
      window(m);
      i_event_source_model.pulses(3);
      rd(freq_counter_pkg::RESULT_ADDR, n + m, 32'hffffffff);
      chk(32'(irq_t.size()), 32'h3);
      // Gate mode against a steady input level.
      for (int g = 0; g < 4; g++) begin
         wr(freq_counter_pkg::CTRL_ONE_ADDR, 8'h0c);
         wr(freq_counter_pkg::CTRL_TWO_ADDR, {4'h0, g[1], 3'h0});
         i_event_source_model.hold(g[0]);
         wr(freq_counter_pkg::CTRL_ONE_ADDR, 8'h1e);
         window(0);
         rd(freq_counter_pkg::RESULT_ADDR, 32'(g[0] | g[1]), 32'hffffffff);
      end
      i_event_source_model.hold(1'b0);
      // Wrap past the narrow counter's maximum, then clear.
      wr(freq_counter_pkg::CTRL_ONE_ADDR, 8'h0c);
      wr(freq_counter_pkg::CTRL_TWO_ADDR, 8'h00);
      wr(freq_counter_pkg::CTRL_ONE_ADDR, 8'h1e);
      window(17);
      rd(freq_counter_pkg::RESULT_ADDR, 32'h1, 32'hffffffff);
      rd(freq_counter_pkg::STATUS_ADDR, 32'h40, 32'h40);
      window(2);
      rd(freq_counter_pkg::STATUS_ADDR, 32'h40, 32'h40);
      wr(freq_counter_pkg::CTRL_ONE_ADDR, 8'h1e);
      rd(freq_counter_pkg::STATUS_ADDR, 32'h0, 32'h40);
      rd(freq_counter_pkg::RESULT_ADDR, 32'h0, 32'hffffffff);
      // Random neighbour output as gate, mode 1: every gate fall adds one and interrupts.
      wr(freq_counter_pkg::CTRL_ONE_ADDR, 8'h0c);
      wr(freq_counter_pkg::CTRL_TWO_ADDR, 8'h09);
      irq_t.delete();
      wr(freq_counter_pkg::CTRL_ONE_ADDR, 8'h1e);
      repeat (12) @(posedge clk_in);
      wr(freq_counter_pkg::CTRL_ONE_ADDR, 8'h0c);
      repeat (4) @(posedge clk_in);
      rd(freq_counter_pkg::RESULT_ADDR, 32'(irq_t.size()), 32'hffffffff);
      // Internal gate on the fs path for prescale codes 0 to 2.
      for (int p = 0; p < 3; p++) begin
         wr(freq_counter_pkg::CTRL_ONE_ADDR, 8'h0c);
         wr(freq_counter_pkg::CTRL_TWO_ADDR, {2'h1, 2'(p), 4'h6});
         wr(freq_counter_pkg::PERIOD_ADDR, 8'hfe);
         repeat (20) @(posedge clk_in);
         irq_t.delete();
         wr(freq_counter_pkg::CTRL_ONE_ADDR, 8'h0e);
         s = cyc;
         t = 128 << p;
         wait_irq(2);
         wr(freq_counter_pkg::PERIOD_ADDR, 8'hee);
         wait_irq(5);
         chk(32'(irq_t[0] - s <= t + 16), 32'h1);
         chk(irq_t[1] - irq_t[0], 2 * t);
         chk(irq_t[2] - irq_t[1], t);
         chk(irq_t[3] - irq_t[2], 2 * t);
         chk(irq_t[4] - irq_t[3], 2 * t);
      end
      // Internal gate on the fc path: one-tick phases of 2^12 clocks each.
      wr(freq_counter_pkg::CTRL_ONE_ADDR, 8'h0c);
      wr(freq_counter_pkg::CTRL_TWO_ADDR, 8'h06);
      wr(freq_counter_pkg::PERIOD_ADDR, 8'hff);
      repeat (4) @(posedge clk_in);
      irq_t.delete();
      wr(freq_counter_pkg::CTRL_ONE_ADDR, 8'h0e);
      wait_irq(3);
      chk(irq_t[1] - irq_t[0], 1 << freq_counter_pkg::FC_SHIFT);
      chk(irq_t[2] - irq_t[1], 1 << freq_counter_pkg::FC_SHIFT);
      end_sim();
   end
endmodule // gated_frequency_counter_bench
`default_nettype wire

// File: tb/gated_frequency_counter_checker.sv
// Port-level assertions for the gated frequency counter.
`timescale 1ns/100ps
`default_nettype none
module gated_frequency_counter_checker #(
   parameter int COUNT_W = 18
) (
   input wire logic        clk_in,
   input wire logic        resetn_in,
   input wire logic [4:0]  addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [31:0] rdata_out,
   input wire logic        external_gate_input_in,
   input wire logic        neighbor_timer_output_in,
   input wire logic        counter_interrupt_out,
   input wire logic        shared_port_pin_out
);
   logic       run;
   logic       pin_fall;
   logic       route;
   logic [3:0] idle;
   // =====================================================
   // Shadow of the control fields, rebuilt from bus writes.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         run <= 1'b0;
         pin_fall <= 1'b0;
         route <= 1'b0;
      end else if (wr_in && addr_in == freq_counter_pkg::CTRL_ONE_ADDR) begin
         run <= wdata_in[3:0] == 4'he;
      end else if (wr_in && addr_in == freq_counter_pkg::CTRL_TWO_ADDR) begin
         pin_fall <= wdata_in[2:0] == 3'h0;
         route <= wdata_in[7];
      end
   end
   // Saturating count of stopped cycles; a stop may itself raise one interrupt.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) idle <= 4'h0;
      else if (run) idle <= 4'h0;
      else if (idle != 4'hf) idle <= idle + 4'h1;
   end
   // =====================================================
   // Properties.
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   sequence rd_at(logic [4:0] a);
      rd_in && addr_in == a;
   endsequence
   sequence gate_fall_s;
      run && pin_fall && $fell(external_gate_input_in);
   endsequence
   rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
      else $error("read data not zero outside read slot");
   unmapped_read_a: assert property (rd_in && addr_in > freq_counter_pkg::STATUS_ADDR
      |=> rdata_out == 32'h0) else $error("unmapped read not zero");
   result_width_a: assert property (rd_at(freq_counter_pkg::RESULT_ADDR)
      |=> (rdata_out >> COUNT_W) == 32'h0) else $error("result too wide");
   status_spare_a: assert property (rd_at(freq_counter_pkg::STATUS_ADDR)
      |=> rdata_out[5:0] == 6'h0) else $error("status spare bits set");
   clear_reads0_a: assert property (rd_at(freq_counter_pkg::CTRL_ONE_ADDR)
      |=> !rdata_out[4]) else $error("clear bit reads one");
   irq_pulse_a: assert property (counter_interrupt_out |=> !counter_interrupt_out)
      else $error("interrupt longer than one cycle");
   irq_fall_a: assert property (gate_fall_s |-> ##[1:6] counter_interrupt_out)
      else $error("no interrupt after gate fall");
   stopped_quiet_a: assert property (idle == 4'hf |-> !counter_interrupt_out)
      else $error("interrupt while stopped");
   stopped_flag_a: assert property (idle == 4'hf && rd_in &&
      addr_in == freq_counter_pkg::STATUS_ADDR |=> !rdata_out[7])
      else $error("window flag set while stopped");
   port_pin_a: assert property ($past(resetn_in) |-> shared_port_pin_out ==
      (!$past(route) && $past(neighbor_timer_output_in)))
      else $error("port pin does not follow route bit");
endmodule // gated_frequency_counter_checker
bind gated_frequency_counter gated_frequency_counter_checker #(.COUNT_W(COUNT_W))
   i_gated_frequency_counter_checker (.clk_in(clk_in), .resetn_in(resetn_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .external_gate_input_in(external_gate_input_in),
   .neighbor_timer_output_in(neighbor_timer_output_in),
   .counter_interrupt_out(counter_interrupt_out),
   .shared_port_pin_out(shared_port_pin_out));
`default_nettype wire
